// ==== rtl/aqf_framer.sv ====
// Purpose: Parses queued-command and legacy-transmit API frames
// Assumes: rx byte stream and answer consumers run on sys_clk
// Notes:   Payload leaves through a FIFO; a tail entry marks the verdict
`timescale 1ns/1ns
module aqf_framer
	import aqf_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  nrst,
	// APB slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	// Received bytes from UART
	input  wire logic [7:0]            rx_data,
	input  wire logic                  rx_valid,
	output logic                       rx_ready,
	// Module temperature sample
	input  wire logic [7:0]            temp_value,
	// Answer to host
	output logic                       resp_valid,
	input  wire logic                  resp_ready,
	output logic [7:0]                 resp_type,
	output logic [7:0]                 resp_frame_id,
	output logic [15:0]                resp_cmd,
	output logic [7:0]                 resp_status,
	output logic [15:0]                resp_value,
	// Active settings
	output logic [7:0]                 serial_rate,
	output logic                       api_escaped,
	// Legacy transmit request
	output logic [63:0]                tx_dest,
	output logic [7:0]                 tx_options,
	output logic                       tx_bcast,
	output logic                       tx_start,
	// Payload stream
	output logic                       pay_valid,
	input  wire logic                  pay_ready,
	output logic [7:0]                 pay_data,
	output logic                       pay_end,
	output logic                       pay_good
);
	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	aqf_state_t                  st;
	logic [15:0]                 len;
	logic [15:0]                 idx;
	logic [7:0]                  sum;
	logic                        esc_pend;
	logic [7:0]                  ftype;
	logic [7:0]                  fid;
	logic [15:0]                 cmd;
	logic [7:0]                  param;
	logic [63:0]                 dest;
	logic [7:0]                  opts;
	logic [15:0]                 pay_cnt;
	logic                        pay_over;
	logic [7:0]                  rate_staged;
	logic                        rate_pend;
	logic [7:0]                  framing;
	logic [7:0]                  framing_staged;
	logic                        framing_pend;
	logic [15:0]                 max_payload;
	logic                        parse_en;
	logic [7:0]                  good_cnt;
	logic [7:0]                  bad_cnt;
	logic                        byte_take;
	logic                        raw_start;
	logic                        esc_mark;
	logic                        dvalid;
	logic [7:0]                  dbyte;
	logic                        done;
	logic                        good;
	logic                        cmd_frame;
	logic                        is_query;
	logic                        apply_now;
	logic                        act_cmd;
	logic                        pay_push;
	logic                        tail_push;
	logic [FIFO_WIDTH-1:0]       fifo_in;
	logic [FIFO_WIDTH-1:0]       fifo_out;
	logic                        fifo_in_ready;
	logic [$clog2(DEPTH):0]      fifo_level;
	logic                        apb_wr;
	logic                        apb_rd;
	logic [31:0]                 rd_mux;
	logic                        rd_hit;

	function automatic logic known_cmd(input logic [15:0] c);
		known_cmd = (c == CMD_APPLY) || (c == CMD_RATE) || (c == CMD_FRAMING) ||
			(c == CMD_MAXPAY) || (c == CMD_TEMP);
	endfunction

	function automatic logic settable_cmd(input logic [15:0] c);
		settable_cmd = (c == CMD_RATE) || (c == CMD_FRAMING) || (c == CMD_APPLY);
	endfunction

	// ------------------------------------------------------------
	// Byte intake and unescaping
	// ------------------------------------------------------------
	// Flop output; the stall after a checksum byte covers the lag
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			api_escaped <= 1'b0;
		end else begin
			api_escaped <= (framing == FRAMING_ESC);
		end
	end
	assign byte_take   = rx_valid && rx_ready;
	// Escaped data never holds a raw start byte, so it always resyncs
	assign raw_start   = byte_take && (rx_data == START_BYTE) && !esc_pend &&
		(api_escaped || st == PS_IDLE);
	assign esc_mark    = byte_take && api_escaped && (rx_data == ESC_BYTE) && !esc_pend;
	assign dvalid      = byte_take && !raw_start && !esc_mark;
	assign dbyte       = esc_pend ? (rx_data ^ ESC_XOR) : rx_data;
	assign done        = dvalid && (st == PS_CHK);
	assign good        = (8'(sum + dbyte) == CKSUM_GOOD);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			esc_pend <= 1'b0;
		end else if (raw_start || dvalid) begin
			esc_pend <= 1'b0;
		end else if (esc_mark) begin
			esc_pend <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Frame sequencer
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st  <= PS_IDLE;
			len <= '0;
			idx <= '0;
			sum <= '0;
		end else if (raw_start) begin
			st  <= PS_LEN_HI;
			idx <= '0;
			sum <= '0;
		end else if (dvalid) begin
			case (st)
				PS_IDLE: begin
					st <= PS_IDLE;
				end
				PS_LEN_HI: begin
					len[15:8] <= dbyte;
					st        <= PS_LEN_LO;
				end
				PS_LEN_LO: begin
					len[7:0] <= dbyte;
					st       <= ({len[15:8], dbyte} == 16'h0000) ? PS_CHK : PS_BODY;
				end
				PS_BODY: begin
					sum <= sum + dbyte;
					idx <= idx + 16'h0001;
					if (idx + 16'h0001 == len) begin
						st <= PS_CHK;
					end
				end
				PS_CHK: begin
					st <= PS_IDLE;
				end
				default: begin
					st <= PS_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Field capture
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ftype <= '0;
			fid   <= '0;
			cmd   <= '0;
			param <= '0;
			dest  <= '0;
			opts  <= '0;
		end else if (raw_start) begin
			fid <= '0;
		end else if (dvalid && st == PS_BODY) begin
			if (idx == IDX_TYPE) begin
				ftype <= dbyte;
			end
			if (idx == IDX_FID) begin
				fid <= dbyte;
			end
			if (idx == IDX_CMD_HI) begin
				cmd[15:8] <= dbyte;
			end
			if (idx == IDX_CMD_LO) begin
				cmd[7:0] <= dbyte;
			end
			if (idx >= IDX_PARAM) begin
				param <= dbyte;
			end
			if (idx >= IDX_DEST_LO && idx <= IDX_DEST_HI) begin
				dest <= {dest[55:0], dbyte};
			end
			if (idx == IDX_OPT) begin
				opts <= dbyte;
			end
		end
	end

	// ------------------------------------------------------------
	// Payload into FIFO
	// ------------------------------------------------------------
	// Bytes go out before the checksum is known; the tail entry
	// carries the verdict so the consumer can drop a bad frame.
	assign pay_push  = dvalid && (st == PS_BODY) && (ftype == TYPE_LEGACY) &&
		(idx >= IDX_PAYLOAD) && (pay_cnt < max_payload);
	assign tail_push = ((done && len > IDX_PAYLOAD) ||
		(raw_start && st == PS_BODY && idx > IDX_PAYLOAD)) && (ftype == TYPE_LEGACY);
	assign fifo_in   = tail_push ? {1'b1, done && good && !pay_over, 8'h00} : {2'b00, dbyte};

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pay_cnt  <= '0;
			pay_over <= 1'b0;
		end else if (raw_start) begin
			pay_cnt  <= '0;
			pay_over <= 1'b0;
		end else if (dvalid && st == PS_BODY && idx >= IDX_PAYLOAD) begin
			if (pay_cnt < max_payload) begin
				pay_cnt <= pay_cnt + 16'h0001;
			end else begin
				pay_over <= 1'b1;
			end
		end
	end

	aqf_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk       (sys_clk),
		.rst_n     (rst_n),
		.in_valid  (pay_push || tail_push),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in),
		.out_valid (pay_valid),
		.out_ready (pay_ready),
		.out_data  (fifo_out),
		.level     (fifo_level)
	);

	assign pay_data = fifo_out[7:0];
	assign pay_good = fifo_out[8];
	assign pay_end  = fifo_out[9];

	// Ready is registered, so keep two free slots to cover the lag
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_ready <= 1'b0;
		end else begin
			rx_ready <= parse_en && fifo_in_ready && (fifo_level <= ($clog2(DEPTH)+1)'(DEPTH - 2)) &&
				!resp_valid && !(byte_take && st == PS_CHK);
		end
	end

	// ------------------------------------------------------------
	// Settings: active and staged
	// ------------------------------------------------------------
	assign cmd_frame = (ftype == TYPE_IMM || ftype == TYPE_QUEUE) && (len >= LEN_QUERY);
	assign is_query  = (len == LEN_QUERY);
	assign act_cmd   = done && good && cmd_frame && known_cmd(cmd);
	assign apply_now = (ftype == TYPE_IMM) || (cmd == CMD_APPLY);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			serial_rate    <= RST_RATE;
			rate_staged    <= RST_RATE;
			rate_pend      <= 1'b0;
			framing        <= RST_FRAMING;
			framing_staged <= RST_FRAMING;
			framing_pend   <= 1'b0;
		end else if (act_cmd) begin
			if (apply_now) begin
				if (rate_pend) begin
					serial_rate <= rate_staged;
				end
				if (framing_pend) begin
					framing <= framing_staged;
				end
				rate_pend    <= 1'b0;
				framing_pend <= 1'b0;
			end
			if (!is_query && cmd == CMD_RATE) begin
				if (ftype == TYPE_IMM) begin
					serial_rate <= param;
				end else begin
					rate_staged <= param;
					rate_pend   <= 1'b1;
				end
			end
			if (!is_query && cmd == CMD_FRAMING) begin
				if (ftype == TYPE_IMM) begin
					framing <= param;
				end else begin
					framing_staged <= param;
					framing_pend   <= 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Legacy transmit latch
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_dest    <= '0;
			tx_options <= '0;
			tx_bcast   <= 1'b0;
			tx_start   <= 1'b0;
		end else begin
			tx_start <= 1'b0;
			if (done && good && ftype == TYPE_LEGACY && len >= IDX_PAYLOAD && !pay_over) begin
				tx_dest    <= dest;
				tx_options <= opts;
				tx_bcast   <= (dest == BCAST_ADDR);
				tx_start   <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Answer to host
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			resp_valid    <= 1'b0;
			resp_type     <= '0;
			resp_frame_id <= '0;
			resp_cmd      <= '0;
			resp_status   <= '0;
			resp_value    <= '0;
		end else if (resp_valid) begin
			if (resp_ready) begin
				resp_valid <= 1'b0;
			end
		end else if (done && good && fid != 8'h00) begin
			if (cmd_frame) begin
				resp_valid    <= 1'b1;
				resp_type     <= RESP_CMD;
				resp_frame_id <= fid;
				resp_cmd      <= cmd;
				resp_status   <= (known_cmd(cmd) && (is_query || settable_cmd(cmd))) ? ST_OK : ST_ERROR;
				if (!is_query || cmd == CMD_APPLY) begin
					resp_value <= 16'h0000;
				end else if (cmd == CMD_RATE) begin
					resp_value <= {8'h00, serial_rate};
				end else if (cmd == CMD_FRAMING) begin
					resp_value <= {8'h00, framing};
				end else if (cmd == CMD_MAXPAY) begin
					resp_value <= max_payload;
				end else begin
					resp_value <= {8'h00, temp_value};
				end
			end else if (ftype == TYPE_LEGACY) begin
				resp_valid    <= 1'b1;
				resp_type     <= RESP_TX;
				resp_frame_id <= fid;
				resp_cmd      <= 16'h0000;
				resp_value    <= 16'h0000;
				resp_status   <= (len < IDX_PAYLOAD) ? ST_ERROR : (pay_over ? ST_TOO_LONG : ST_OK);
			end
		end
	end

	// ------------------------------------------------------------
	// Frame counters
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			good_cnt <= '0;
			bad_cnt  <= '0;
		end else if (done) begin
			if (good) begin
				good_cnt <= good_cnt + 8'h01;
			end else begin
				bad_cnt <= bad_cnt + 8'h01;
			end
		end
	end

	// ------------------------------------------------------------
	// APB registers
	// ------------------------------------------------------------
	assign apb_wr = psel && penable && pready && pwrite;
	assign apb_rd = psel && !penable && !pwrite;

	always_comb begin
		rd_hit = 1'b1;
		rd_mux = 32'h0000_0000;
		case (paddr)
			OFS_CTRL:    rd_mux = {31'h0000_0000, parse_en};
			OFS_STATUS:  rd_mux = {14'h0000, framing_pend, rate_pend, framing, serial_rate};
			OFS_STAGED:  rd_mux = {16'h0000, framing_staged, rate_staged};
			OFS_DEST_LO: rd_mux = tx_dest[31:0];
			OFS_DEST_HI: rd_mux = tx_dest[63:32];
			OFS_TXOPT:   rd_mux = {23'h00_0000, tx_bcast, tx_options};
			OFS_COUNT:   rd_mux = {16'h0000, bad_cnt, good_cnt};
			OFS_MAXPAY:  rd_mux = {16'h0000, max_payload};
			default:     rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !rd_hit;
			prdata  <= apb_rd ? rd_mux : 32'h0000_0000;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			parse_en    <= RST_ENABLE;
			max_payload <= RST_MAXPAY;
		end else if (apb_wr) begin
			if (paddr == OFS_CTRL) begin
				parse_en <= pwdata[0];
			end
			if (paddr == OFS_MAXPAY) begin
				max_payload <= pwdata[15:0];
			end
		end
	end

endmodule

// ==== rtl/aqf_pkg.sv ====
// Purpose: Constants shared by the serial API frame parser and its payload FIFO
// Assumes: Byte stream from UART logic on sys_clk; APB register access
// Notes:   Offsets are byte addresses of 32-bit registers
//
// How it works
// - Start byte, then 16-bit body length
// - Last byte is 0xFF minus body sum
// - Type 0x09 queues command, answered by 0x88
// - Frame identifier zero suppresses the response
// - Response echoes the request frame identifier
// - Staged value applies on 0x08 or apply-changes
// - No parameter bytes means query current value
// - Parameter bytes from seven are staged only in 0x09 frames
// - Staged rate change leaves UART rate alone
// - Type 0x00 legacy transmit, answered by 0x89
// - Eight destination bytes; 0xFFFF means broadcast
// - Options bit0 no ack, bit2 broadcast network
// - Payload from fourteen, bounded by maximum size
// - Escaped mode: 0x7D then byte XOR 0x20
package aqf_pkg;

	// ------------------------------------------------------------
	// Framing
	// ------------------------------------------------------------
	localparam logic [7:0]  START_BYTE   = 8'h7E;
	localparam logic [7:0]  ESC_BYTE     = 8'h7D;
	localparam logic [7:0]  ESC_XOR      = 8'h20;
	localparam logic [7:0]  CKSUM_GOOD   = 8'hFF;
	localparam logic [7:0]  TYPE_IMM     = 8'h08;
	localparam logic [7:0]  TYPE_QUEUE   = 8'h09;
	localparam logic [7:0]  TYPE_LEGACY  = 8'h00;
	localparam logic [7:0]  RESP_CMD     = 8'h88;
	localparam logic [7:0]  RESP_TX      = 8'h89;

	// Body indices (frame offset minus three)
	localparam logic [15:0] IDX_TYPE     = 16'h0000;
	localparam logic [15:0] IDX_FID      = 16'h0001;
	localparam logic [15:0] IDX_CMD_HI   = 16'h0002;
	localparam logic [15:0] IDX_CMD_LO   = 16'h0003;
	localparam logic [15:0] IDX_PARAM    = 16'h0004;
	localparam logic [15:0] IDX_DEST_LO  = 16'h0002;
	localparam logic [15:0] IDX_DEST_HI  = 16'h0009;
	localparam logic [15:0] IDX_OPT      = 16'h000A;
	localparam logic [15:0] IDX_PAYLOAD  = 16'h000B;
	localparam logic [15:0] LEN_QUERY    = 16'h0004;

	localparam logic [63:0] BCAST_ADDR   = 64'h0000_0000_0000_FFFF;
	localparam int          OPT_NO_ACK   = 0;
	localparam int          OPT_BCAST_NW = 2;

	// ------------------------------------------------------------
	// Command codes and settings
	// ------------------------------------------------------------
	localparam logic [15:0] CMD_APPLY    = 16'h4143;
	localparam logic [15:0] CMD_RATE     = 16'h4244;
	localparam logic [15:0] CMD_FRAMING  = 16'h4150;
	localparam logic [15:0] CMD_MAXPAY   = 16'h4E50;
	localparam logic [15:0] CMD_TEMP     = 16'h5450;
	localparam logic [7:0]  FRAMING_ESC  = 8'h02;
	localparam logic [7:0]  RST_RATE     = 8'h03;
	localparam logic [7:0]  RST_FRAMING  = 8'h01;
	localparam logic [15:0] RST_MAXPAY   = 16'h0100;

	localparam logic [7:0]  ST_OK        = 8'h00;
	localparam logic [7:0]  ST_ERROR     = 8'h01;
	localparam logic [7:0]  ST_TOO_LONG  = 8'h74;

	// ------------------------------------------------------------
	// Registers and FIFO
	// ------------------------------------------------------------
	localparam logic [7:0]  OFS_CTRL     = 8'h00;
	localparam logic [7:0]  OFS_STATUS   = 8'h04;
	localparam logic [7:0]  OFS_STAGED   = 8'h08;
	localparam logic [7:0]  OFS_DEST_LO  = 8'h0C;
	localparam logic [7:0]  OFS_DEST_HI  = 8'h10;
	localparam logic [7:0]  OFS_TXOPT    = 8'h14;
	localparam logic [7:0]  OFS_COUNT    = 8'h18;
	localparam logic [7:0]  OFS_MAXPAY   = 8'h1C;
	localparam logic        RST_ENABLE   = 1'b1;
	localparam int          FIFO_DEPTH   = 16;
	localparam int          FIFO_WIDTH   = 10;

	typedef enum logic [2:0] {
		PS_IDLE,
		PS_LEN_HI,
		PS_LEN_LO,
		PS_BODY,
		PS_CHK
	} aqf_state_t;

endpackage

// ==== rtl/aqf_fifo.sv ====
// Purpose: Synchronous FIFO with valid/ready on both sides
// Assumes: One clock, reset already synchronised
// Notes:   Level output lets the writer stall ahead of full
`timescale 1ns/1ns
module aqf_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	// Write side
	input  wire logic                       in_valid,
	output logic                            in_ready,
	input  wire logic [WIDTH-1:0]           in_data,
	// Read side
	output logic                            out_valid,
	input  wire logic                       out_ready,
	output logic [WIDTH-1:0]                out_data,
	// Fill level
	output logic [$clog2(DEPTH):0]          level
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic             push;
	logic             pop;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
	endfunction

	assign in_ready  = (level != (AW+1)'(DEPTH));
	assign out_valid = (level != '0);
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= bump(wr_ptr);
			end
			if (pop) begin
				rd_ptr <= bump(rd_ptr);
			end
			level <= level + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule

// ==== test/aqf_framer_props.sv ====
// Purpose: Port assertions for the API frame parser
// Assumes: One sys_clk domain, nrst active low
// Notes:   Bound into every parser instance
`timescale 1ns/1ns
module aqf_framer_props (
	input wire logic        sys_clk,
	input wire logic        nrst,
	input wire logic        rx_valid,
	input wire logic        rx_ready,
	input wire logic        resp_valid,
	input wire logic        resp_ready,
	input wire logic [7:0]  resp_type,
	input wire logic [7:0]  resp_frame_id,
	input wire logic [7:0]  serial_rate,
	input wire logic [63:0] tx_dest,
	input wire logic        tx_bcast,
	input wire logic        tx_start
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	wire take = rx_valid && rx_ready;
	AST_RESP_CAUSE: assert property ($rose(resp_valid) |-> $past(take))
		else $error("answer without a checksum byte");
	AST_RESP_HOLD: assert property (resp_valid && !resp_ready |=> resp_valid && $stable(resp_frame_id))
		else $error("answer dropped or changed");
	AST_RESP_KIND: assert property (resp_valid |-> resp_type inside {8'h88, 8'h89})
		else $error("bad answer type");
	AST_FID_ZERO: assert property (resp_valid |-> resp_frame_id != 8'h00)
		else $error("answer for frame id zero");
	AST_RX_STALL: assert property (resp_valid |-> !rx_ready)
		else $error("input open with answer pending");
	AST_TX_PULSE: assert property (tx_start |=> !tx_start)
		else $error("start pulse too long");
	AST_BCAST: assert property (tx_start |-> tx_bcast == (tx_dest == 64'h0000_0000_0000_FFFF))
		else $error("broadcast flag wrong");
	AST_RATE_HOLD: assert property ($changed(serial_rate) |-> $past(take))
		else $error("rate changed outside a frame");
	C_QRESP: cover property ($rose(resp_valid) && resp_type == 8'h88);
	C_TRESP: cover property ($rose(resp_valid) && resp_type == 8'h89);
	C_BCAST: cover property (tx_start && tx_bcast);
endmodule
bind aqf_framer aqf_framer_props i_props (.sys_clk, .nrst, .rx_valid, .rx_ready, .resp_valid,
	.resp_ready, .resp_type, .resp_frame_id, .serial_rate, .tx_dest, .tx_bcast, .tx_start);

// ==== test/aqf_host.sv ====
// Purpose: Host model feeding API frames byte by byte
// Assumes: Escaped framing only while esc is set
// Notes:   Random gaps between bytes when slow
`timescale 1ns/1ns
module aqf_host (
	input wire logic        clk,
	input wire logic        rx_ready,
	input wire logic        slow,
	output logic [7:0]      rx_data,
	output logic            rx_valid
);
	logic [7:0] q[$];
	logic       esc = 1'b0;
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
	end
	// Idle data is scrambled so nobody leans on a stale byte
	always @(posedge clk) begin
		if (!rx_valid || rx_ready) begin
			if (rx_valid)
				void'(q.pop_front());
			if (q.size() > 0 && !(slow && $urandom_range(1) == 0)) begin
				rx_valid <= 1'b1;
				rx_data <= q[0];
			end else begin
				rx_valid <= 1'b0;
				rx_data <= ~rx_data;
			end
		end
	end
	function automatic void put(input logic [7:0] v);
		if (esc && v inside {8'h7E, 8'h7D, 8'h11, 8'h13}) begin
			q.push_back(8'h7D);
			q.push_back(v ^ 8'h20);
		end else
			q.push_back(v);
	endfunction
	task automatic send(input logic [7:0] b[$], input logic bad);
		logic [7:0] s;
		s = 8'h00;
		foreach (b[i]) s += b[i];
		q.push_back(8'h7E);
		put(8'(b.size() >> 8));
		put(8'(b.size()));
		foreach (b[i]) put(b[i]);
		put(8'hFF - s ^ {7'h00, bad});
	endtask
endmodule

// ==== test/tb_aqf_framer.sv ====
// Purpose: Self-checking bench for the API frame parser
// Assumes: Host model feeds bytes; bench drains answers
// Notes:   Seeded random legacy frames plus fixed corner cases
`timescale 1ns/1ns
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin err_total++; \
	$display("[ERR] %s exp %0h got %0h", n, e, s); end end
module tb_aqf_framer
	import aqf_pkg::*;
;
	logic        sys_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        resp_ready = 1'b0, pay_ready = 1'b0, stall = 1'b0, err;
	logic [7:0]  paddr = 8'h00, temp_value = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, rx_ready, rx_valid, resp_valid, tx_start, pay_valid;
	logic        pay_end, pay_good, api_escaped, tx_bcast;
	logic [7:0]  rx_data, resp_type, resp_frame_id, resp_status, serial_rate, tx_options, pay_data;
	logic [15:0] resp_cmd, resp_value;
	logic [63:0] tx_dest;
	logic [55:0] rq[$];
	logic [9:0]  pq[$];
	int          err_total = 0, checked = 0;
	always #10 sys_clk = ~sys_clk;
	aqf_framer i_dut (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .rx_data, .rx_valid, .rx_ready, .temp_value, .resp_valid, .resp_ready, .resp_type,
		.resp_frame_id, .resp_cmd, .resp_status, .resp_value, .serial_rate, .api_escaped, .tx_dest,
		.tx_options, .tx_bcast, .tx_start, .pay_valid, .pay_ready, .pay_data, .pay_end, .pay_good);
	aqf_host i_host (.clk(sys_clk), .rx_ready, .slow(1'b1), .rx_data, .rx_valid);
	always @(posedge sys_clk) begin
		if (resp_valid && resp_ready)
			rq.push_back({resp_type, resp_frame_id, resp_cmd, resp_status, resp_value});
		if (pay_valid && pay_ready)
			pq.push_back({pay_end, pay_good, pay_data});
		resp_ready <= 1'($urandom_range(1));
		pay_ready <= !stall && 1'($urandom_range(1));
	end
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do
			@(posedge sys_clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic get(input logic [55:0] e, input logic [55:0] m);
		logic [55:0] r;
		for (int k = 0; k < 600 && rq.size() == 0; k++)
			@(posedge sys_clk);
		r = rq.size() > 0 ? rq.pop_front() : 56'hx;
		`CHK("resp", e & m, r & m)
	endtask
	task automatic end_of_test();
		if (err_total == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#2000000;
		err_total++;
		end_of_test();
	end
	initial begin
		void'($urandom(32'h70f4f7af));
		temp_value = 8'($urandom);
		repeat (16) @(posedge sys_clk);
		nrst <= 1'b1;
		i_host.send('{8'h09, 8'h17, 8'h54, 8'h50}, 1'b0);
		get({RESP_CMD, 8'h17, CMD_TEMP, ST_OK, 8'h00, temp_value}, '1);
		i_host.send('{8'h09, 8'h53, 8'h42, 8'h44, 8'h07}, 1'b0);
		get({RESP_CMD, 8'h53, CMD_RATE, ST_OK, 16'h0}, {40'hFF_FFFF_FFFF, 16'h0});
		`CHK("rate", 8'h03, serial_rate)
		apb(1'b0, OFS_STAGED, 32'h0);
		`CHK("staged", 8'h07, rd[7:0])
		i_host.send('{8'h09, 8'h21, 8'h42, 8'h44}, 1'b0);
		get({RESP_CMD, 8'h21, CMD_RATE, ST_OK, 16'h0003}, '1);
		i_host.send('{8'h09, 8'h00, 8'h41, 8'h43}, 1'b0);
		i_host.send('{8'h09, 8'h31, 8'h42, 8'h44}, 1'b1);
		i_host.send('{8'h09, 8'h32, 8'h42, 8'h44}, 1'b0);
		get({RESP_CMD, 8'h32, CMD_RATE, ST_OK, 16'h0007}, '1);
		`CHK("rate", 8'h07, serial_rate)
		apb(1'b0, OFS_MAXPAY, 32'h0);
		`CHK("maxpay", 32'h100, rd)
		apb(1'b0, 8'h40, 32'h0);
		`CHK("unmapped", 1'b1, err)
		i_host.send('{8'h08, 8'h41, 8'h41, 8'h50, 8'h02}, 1'b0);
		get({RESP_CMD, 8'h41, CMD_FRAMING, ST_OK, 16'h0}, '1);
		@(posedge sys_clk);
		i_host.esc = 1'b1;
		`CHK("escaped", 1'b1, api_escaped)
		i_host.send('{8'h09, 8'h7D, 8'h41, 8'h50}, 1'b0);
		get({RESP_CMD, 8'h7D, CMD_FRAMING, ST_OK, 16'h0002}, '1);
		for (int i = 0; i < 4; i++) begin
			int n, nc;
			logic [7:0] b[$];
			logic [63:0] d;
			logic [7:0] o, f;
			n = i == 0 ? 16 : i == 3 ? 6 : $urandom_range(1, 6);
			nc = i == 3 ? 4 : n;
			d = i == 1 ? BCAST_ADDR : {$urandom, $urandom};
			o = 8'({i[1], 1'b0, i[0]});
			f = 8'($urandom_range(1, 255));
			b = '{8'h00, f};
			for (int k = 7; k >= 0; k--) b.push_back(d[k*8 +: 8]);
			b.push_back(o);
			for (int k = 0; k < n; k++) b.push_back(8'($urandom));
			if (i == 3)
				apb(1'b1, OFS_MAXPAY, 32'h4);
			stall <= i == 0;
			repeat (30) @(posedge sys_clk);
			pq.delete();
			i_host.send(b, 1'b0);
			if (i == 0) begin
				repeat (100) @(posedge sys_clk);
				`CHK("fifo full", 1'b0, rx_ready)
				stall <= 1'b0;
			end
			get({RESP_TX, f, 16'h0, i == 3 ? ST_TOO_LONG : ST_OK, 16'h0}, {16'hFFFF, 16'h0, 8'hFF, 16'h0});
			if (i != 3) begin
				`CHK("dest", d, tx_dest)
				`CHK("opts", {d == BCAST_ADDR, o}, {tx_bcast, tx_options})
			end
			for (int k = 0; k < 600 && pq.size() <= nc; k++)
				@(posedge sys_clk);
			for (int k = 0; k < nc; k++) `CHK("pay", {2'b00, b[11+k]}, pq[k])
			`CHK("tail", {1'b1, i != 3}, pq[nc][9:8])
		end
		end_of_test();
	end
endmodule
